// ### afc_ahb_slave.sv
// ahb-lite slave front end for the flow control registers
`timescale 1ns/1ps
module afc_ahb_slave (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic [7:0]       rd_addr,
    input  wire logic [31:0] rd_data,
    output logic             wr_en,
    output logic [7:0]       wr_addr,
    output logic [31:0]      wr_data
);
    logic       valid;
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;

    // only whole-word transfers are issued, so hsize is not decoded
    assign valid     = hsel && hready && (htrans == afc_pkg::HTRANS_NONSEQ
                                          || htrans == afc_pkg::HTRANS_SEQ);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign rd_addr   = haddr[7:0];
    assign wr_en     = wr_pend_q;
    assign wr_addr   = wr_addr_q;
    assign wr_data   = hwdata;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= valid && hwrite;
            if (valid) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    // read data is sampled in the address phase so it stands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (valid && !hwrite) begin
            hrdata <= rd_data;
        end
    end

    logic unused_size;
    assign unused_size = ^hsize;
endmodule

// ### afc_fabric_model.sv
// switch fabric port model that takes pause frames from the host mac
`timescale 1ns/1ps
module afc_fabric_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        pause_req,
    input  wire logic [15:0] pause_time,
    input  wire logic [3:0]  ack_dly,
    output logic             pause_ack,
    output logic [7:0]       n_pause,
    output logic [15:0]      last_time
);
    logic [3:0] wait_q;

    // ack is a one-cycle pulse; a slow ack_dly shows the request must stand
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_ack <= 1'b0;
            wait_q    <= 4'h0;
            n_pause   <= 8'h00;
            last_time <= 16'h0000;
        end else begin
            pause_ack <= 1'b0;
            if (pause_req && !pause_ack) begin
                if (wait_q >= ack_dly) begin
                    pause_ack <= 1'b1;
                    n_pause   <= n_pause + 8'h01;
                    last_time <= pause_time;
                    wait_q    <= 4'h0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule

// ### afc_jam_timer.sv
// down counter that holds backpressure for a loaded number of cycles
`timescale 1ns/1ps
module afc_jam_timer #(
    parameter int W = afc_pkg::JAM_CNT_W
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         start,
    input  wire logic         abort,
    input  wire logic [W-1:0] dur_cyc,
    output logic              busy
);
    logic [W-1:0] cnt_q;

    assign busy = (cnt_q != '0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
        end else if (abort) begin
            cnt_q <= '0;
        end else if (start && !busy) begin
            cnt_q <= dur_cyc;
        end else if (busy) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    property p_jam_load;
        @(posedge hclk) disable iff (!hresetn)
        (start && !busy && !abort) |=> (cnt_q == $past(dur_cyc));
    endproperty
    a_jam_load: assert property (p_jam_load) else $error("jam timer load wrong");

    property p_jam_count;
        @(posedge hclk) disable iff (!hresetn)
        (busy && !abort) |=> (cnt_q == $past(cnt_q) - 1'b1);
    endproperty
    a_jam_count: assert property (p_jam_count) else $error("jam timer not counting");
endmodule

// ### afc_pkg.sv
// shared constants and types for the host mac automatic flow control block
package afc_pkg;

    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          JAM_STEP_NS      = 5000;
    localparam int          JAM_10M_EXTRA_NS = 2200;
    localparam int          JAM_STEP_CYC     = (JAM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          JAM_EXTRA_CYC    = (JAM_10M_EXTRA_NS + CLK_PERIOD_NS - 1)
                                               / CLK_PERIOD_NS;
    localparam int          JAM_CNT_W        = 17;

    localparam logic [7:0]  CFG_OFS          = 8'hac;
    localparam logic [7:0]  STATUS_OFS       = 8'hb0;
    localparam logic [31:0] CFG_RESET        = 32'h0000_0000;
    localparam logic [31:0] CFG_WMASK        = 32'h00ff_ffff;
    localparam int          LVL_SHIFT        = 6;

    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ       = 2'h3;

    localparam logic [3:0]  DUR_CODE_25US    = 4'h3;
    localparam logic [3:0]  DUR_CODE_50US    = 4'h4;
    localparam logic [7:0]  DUR_MULT_25US    = 8'h05;
    localparam logic [7:0]  DUR_MULT_50US    = 8'h0a;
    localparam logic [7:0]  DUR_MULT_STEP    = 8'h0a;
    localparam logic [3:0]  DUR_CODE_BASE    = 4'h3;

    typedef struct packed {
        logic [7:0] rsvd;
        logic [7:0] high_threshold;
        logic [7:0] low_threshold;
        logic [3:0] jam_duration_code;
        logic       multicast_trigger_en;
        logic       broadcast_trigger_en;
        logic       address_match_trigger_en;
        logic       any_frame_trigger_en;
    } afc_conf_t;

    typedef struct packed {
        logic [15:0] fifo_used;
        logic [11:0] rsvd;
        logic        jam_active;
        logic        pause_sent;
        logic        pause_pending;
        logic        high_reached;
    } afc_status_t;

    typedef struct packed {
        logic preamble;
        logic hdr_valid;
        logic multicast;
        logic broadcast;
        logic addr_match;
    } afc_rx_evt_t;

    typedef enum logic [1:0] {
        FC_IDLE,
        FC_SEND_HI,
        FC_PAUSED,
        FC_SEND_ZERO
    } afc_fc_state_t;

endpackage

// ### afc_top.sv
// automatic flow control of the host mac toward the switch fabric
`timescale 1ns/1ps
module afc_top #(
    parameter int JAM_STEP_CYC  = afc_pkg::JAM_STEP_CYC,
    parameter int JAM_EXTRA_CYC = afc_pkg::JAM_EXTRA_CYC
) (
    input  wire logic                hclk,
    input  wire logic                hresetn,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    input  wire logic [15:0]         rx_fifo_used,
    input  wire afc_pkg::afc_rx_evt_t rx_evt,
    input  wire logic                tx_enabled,
    input  wire logic                full_duplex,
    input  wire logic                speed_100,
    input  wire logic [15:0]         pause_time_value,
    input  wire logic                hardwired_flow_enable,
    output logic                     pause_req,
    output logic [15:0]              pause_time,
    input  wire logic                pause_ack,
    output logic                     backpressure,
    output logic                     hw_flow_assert
);
    localparam int CW = afc_pkg::JAM_CNT_W;

    afc_pkg::afc_conf_t     cfg_q;
    afc_pkg::afc_status_t   status;
    afc_pkg::afc_fc_state_t fc_q;
    logic [7:0]             rd_addr;
    logic [31:0]            rd_data;
    logic                   wr_en;
    logic [7:0]             wr_addr;
    logic [31:0]            wr_data;
    logic                   above_hi;
    logic                   below_lo;
    logic                   high_reached_q;
    logic                   pause_sent_q;
    logic [15:0]            pause_time_q;
    logic                   fd_go;
    logic                   hd_match;
    logic                   jam_start;
    logic                   jam_busy;
    logic [CW-1:0]          jam_cyc;
    logic                   hw_flow_q;

    // threshold in 64-byte units scaled to a byte count
    function automatic logic [16:0] lvl_bytes(input logic [7:0] lvl);
        lvl_bytes = 17'(lvl) << afc_pkg::LVL_SHIFT;
    endfunction

    // step multiplier for the jam duration code, in 5 us steps
    function automatic logic [7:0] dur_mult(input logic [3:0] code);
        if (code < afc_pkg::DUR_CODE_25US) begin
            dur_mult = {4'h0, code} + 8'h01;
        end else if (code == afc_pkg::DUR_CODE_25US) begin
            dur_mult = afc_pkg::DUR_MULT_25US;
        end else if (code == afc_pkg::DUR_CODE_50US) begin
            dur_mult = afc_pkg::DUR_MULT_50US;
        end else begin
            dur_mult = 8'((code - afc_pkg::DUR_CODE_BASE) * afc_pkg::DUR_MULT_STEP);
        end
    endfunction

    afc_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hwdata    (hwdata),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .rd_addr   (rd_addr),
        .rd_data   (rd_data),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data)
    );

    // configuration register; reserved bits never store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= afc_pkg::CFG_RESET;
        end else if (wr_en && wr_addr == afc_pkg::CFG_OFS) begin
            cfg_q <= wr_data & afc_pkg::CFG_WMASK;
        end
    end

    always_comb begin
        status               = '0;
        status.fifo_used     = rx_fifo_used;
        status.jam_active    = backpressure;
        status.pause_sent    = pause_sent_q;
        status.pause_pending = pause_req;
        status.high_reached  = high_reached_q;
    end

    always_comb begin
        if (rd_addr == afc_pkg::CFG_OFS) begin
            rd_data = cfg_q;
        end else if (rd_addr == afc_pkg::STATUS_OFS) begin
            rd_data = status;
        end else begin
            rd_data = 32'h0000_0000;
        end
    end

    // low must sit below high, otherwise the latch below may toggle freely
    assign above_hi = {1'b0, rx_fifo_used} >= lvl_bytes(cfg_q.high_threshold);
    assign below_lo = {1'b0, rx_fifo_used} < lvl_bytes(cfg_q.low_threshold);

    // level held from high threshold until the fill drops below low threshold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            high_reached_q <= 1'b0;
        end else if (above_hi) begin
            high_reached_q <= 1'b1;
        end else if (below_lo) begin
            high_reached_q <= 1'b0;
        end
    end

    // hard-wired flow control shares both thresholds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hw_flow_q <= 1'b0;
        end else begin
            hw_flow_q <= hardwired_flow_enable && (above_hi || (hw_flow_q && !below_lo));
        end
    end
    assign hw_flow_assert = hw_flow_q;

    // full duplex pause only comes from the any-frame trigger
    assign fd_go = tx_enabled && full_duplex && cfg_q.any_frame_trigger_en;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fc_q <= afc_pkg::FC_IDLE;
        end else begin
            case (fc_q)
                afc_pkg::FC_IDLE: begin
                    if (fd_go && above_hi) begin
                        fc_q <= afc_pkg::FC_SEND_HI;
                    end
                end
                afc_pkg::FC_SEND_HI: begin
                    if (!tx_enabled) begin
                        fc_q <= afc_pkg::FC_IDLE;
                    end else if (pause_ack) begin
                        fc_q <= afc_pkg::FC_PAUSED;
                    end
                end
                afc_pkg::FC_PAUSED: begin
                    if (below_lo) begin
                        fc_q <= afc_pkg::FC_SEND_ZERO;
                    end
                end
                afc_pkg::FC_SEND_ZERO: begin
                    if (tx_enabled && pause_ack) begin
                        fc_q <= afc_pkg::FC_IDLE;
                    end
                end
                default: begin
                    fc_q <= afc_pkg::FC_IDLE;
                end
            endcase
        end
    end

    // records that a high-threshold pause frame actually went out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_sent_q <= 1'b0;
        end else if (fc_q == afc_pkg::FC_SEND_HI && tx_enabled && pause_ack) begin
            pause_sent_q <= 1'b1;
        end else if (fc_q == afc_pkg::FC_SEND_ZERO && tx_enabled && pause_ack) begin
            pause_sent_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pause_time_q <= 16'h0000;
        end else if (fc_q == afc_pkg::FC_IDLE && fd_go && above_hi) begin
            pause_time_q <= pause_time_value;
        end else if (fc_q == afc_pkg::FC_PAUSED && below_lo) begin
            pause_time_q <= 16'h0000;
        end
    end
    assign pause_time = pause_time_q;

    // a pending zero pause stays queued while the transmitter is off; a pending high pause is dropped
    assign pause_req = tx_enabled && (fc_q == afc_pkg::FC_SEND_HI
                                      || fc_q == afc_pkg::FC_SEND_ZERO);

    // half duplex frame filter; the any-frame bit jams at preamble with no decode
    always_comb begin
        if (cfg_q.any_frame_trigger_en) begin
            hd_match = rx_evt.preamble;
        end else begin
            hd_match = rx_evt.hdr_valid
                       && ((cfg_q.multicast_trigger_en && rx_evt.multicast)
                        || (cfg_q.broadcast_trigger_en && rx_evt.broadcast)
                        || (cfg_q.address_match_trigger_en && rx_evt.addr_match));
        end
    end

    // only the host mac's own jam is driven here
    assign jam_start = tx_enabled && !full_duplex && high_reached_q && hd_match;

    // duration only consulted for half duplex jams
    assign jam_cyc = CW'(dur_mult(cfg_q.jam_duration_code) * JAM_STEP_CYC
                         + (speed_100 ? 0 : JAM_EXTRA_CYC));

    afc_jam_timer #(
        .W (CW)
    ) u_jam (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (jam_start),
        .abort   (!tx_enabled || full_duplex),
        .dur_cyc (jam_cyc),
        .busy    (jam_busy)
    );

    assign backpressure = jam_busy && tx_enabled && !full_duplex;

    property p_pause_tx_on;
        @(posedge hclk) disable iff (!hresetn)
        pause_req |-> tx_enabled;
    endproperty
    a_pause_tx_on: assert property (p_pause_tx_on) else $error("pause with tx off");

    property p_bp_tx_on;
        @(posedge hclk) disable iff (!hresetn)
        !tx_enabled |-> !backpressure;
    endproperty
    a_bp_tx_on: assert property (p_bp_tx_on) else $error("jam with tx off");

    property p_hi_trigger;
        @(posedge hclk) disable iff (!hresetn)
        (fc_q == afc_pkg::FC_IDLE && tx_enabled && full_duplex && cfg_q.any_frame_trigger_en
         && rx_fifo_used >= {cfg_q.high_threshold, 6'b00_0000})
        |=> (fc_q == afc_pkg::FC_SEND_HI && pause_time == $past(pause_time_value));
    endproperty
    a_hi_trigger: assert property (p_hi_trigger) else $error("no pause at high level");

    property p_zero_time;
        @(posedge hclk) disable iff (!hresetn)
        (fc_q == afc_pkg::FC_SEND_ZERO) |-> (pause_time == 16'h0000 && pause_sent_q);
    endproperty
    a_zero_time: assert property (p_zero_time) else $error("zero pause wrong");

    property p_rearm;
        @(posedge hclk) disable iff (!hresetn)
        (fc_q == afc_pkg::FC_SEND_ZERO && tx_enabled && pause_ack)
        |=> (fc_q == afc_pkg::FC_IDLE && !pause_sent_q);
    endproperty
    a_rearm: assert property (p_rearm) else $error("no re-arm after zero pause");

    property p_no_fd_jam;
        @(posedge hclk) disable iff (!hresetn)
        full_duplex |-> !backpressure;
    endproperty
    a_no_fd_jam: assert property (p_no_fd_jam) else $error("jam in full duplex");

    property p_jam_hd;
        @(posedge hclk) disable iff (!hresetn)
        (jam_start && !jam_busy) |=> backpressure [*2];
    endproperty
    a_jam_hd: assert property (p_jam_hd) else $error("frame match not jammed");

    property p_hw_flow;
        @(posedge hclk) disable iff (!hresetn)
        // the release edge still finds the flops in reset, so skip it
        (hardwired_flow_enable && above_hi && $past(hresetn)) |=> hw_flow_assert;
    endproperty
    a_hw_flow: assert property (p_hw_flow) else $error("hard-wired flow missed");
endmodule

// ### host_mac_auto_flow_control_tb_top.sv
// self-checking testbench for the host mac automatic flow control block
`timescale 1ns/1ps
module host_mac_auto_flow_control_tb_top;
    typedef struct packed {
        logic       spd;
        logic [7:0] cfg;
        logic [4:0] evt;
        logic       hit;
    } afc_row_t;

    logic                 hclk = 1'b0;
    logic                 hresetn = 1'b0;
    logic                 hsel = 1'b0;
    logic                 hwrite = 1'b0;
    logic [31:0]          haddr = 32'h0;
    logic [31:0]          hwdata = 32'h0;
    logic [1:0]           htrans = 2'h0;
    logic [2:0]           hsize = 3'h2;
    logic [15:0]          rx_fifo_used = 16'h0;
    afc_pkg::afc_rx_evt_t rx_evt = '0;
    logic                 tx_enabled = 1'b1;
    logic                 full_duplex = 1'b1;
    logic                 speed_100 = 1'b1;
    logic [15:0]          pause_time_value = 16'h1234;
    logic                 hardwired_flow_enable = 1'b1;
    logic [3:0]           ack_dly = 4'h0;
    logic                 hready, hreadyout, hresp, pause_req, pause_ack;
    logic                 backpressure, hw_flow_assert;
    logic [31:0]          hrdata, rd;
    logic [15:0]          pause_time, last_time;
    logic [7:0]           n_pause;
    int                   failures = 0;
    int                   num_checks = 0;
    // short jam step keeps the longest code near six hundred cycles
    localparam int        STEP = 5;
    localparam int        EXTRA = 2;
    afc_row_t rows [8] = '{'{1'b1, 8'h08, 5'h0c, 1'b1}, '{1'b1, 8'h14, 5'h0a, 1'b1},
                           '{1'b1, 8'h22, 5'h09, 1'b1}, '{1'b1, 8'h31, 5'h10, 1'b1},
                           '{1'b0, 8'h48, 5'h0c, 1'b1}, '{1'b1, 8'h08, 5'h0a, 1'b0},
                           '{1'b1, 8'h06, 5'h0c, 1'b0}, '{1'b0, 8'hf4, 5'h0a, 1'b1}};

    always #5 hclk = ~hclk;
    assign hready = hreadyout;

    afc_top #(.JAM_STEP_CYC(STEP), .JAM_EXTRA_CYC(EXTRA)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .rx_fifo_used(rx_fifo_used),
        .rx_evt(rx_evt), .tx_enabled(tx_enabled), .full_duplex(full_duplex),
        .speed_100(speed_100), .pause_time_value(pause_time_value),
        .hardwired_flow_enable(hardwired_flow_enable), .pause_req(pause_req),
        .pause_time(pause_time), .pause_ack(pause_ack), .backpressure(backpressure),
        .hw_flow_assert(hw_flow_assert));

    afc_fabric_model fab (.hclk(hclk), .hresetn(hresetn), .pause_req(pause_req),
        .pause_time(pause_time), .ack_dly(ack_dly), .pause_ack(pause_ack),
        .n_pause(n_pause), .last_time(last_time));

    task automatic end_sim;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask

    task automatic rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            failures++;
            end_sim;
        end
    endtask

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= afc_pkg::HTRANS_NONSEQ;
        rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask

    task automatic wait_np(input logic [7:0] n);
        for (int k = 0; k < 100 && n_pause !== n; k++) @(posedge hclk);
        chk("pause count", 32'(n), 32'(n_pause));
        if (n_pause !== n) end_sim;
    endtask

    // codes 0..4 are 5,10,15,25,50 us, then 50 us steps, in 5 us units
    function automatic int mult(input logic [3:0] c);
        return c < 3 ? c + 1 : c == 3 ? 5 : c == 4 ? 10 : 20 + 10 * (c - 5);
    endfunction

    task automatic jam(input logic [4:0] e, input int exp);
        int n;
        rx_evt <= e;
        @(posedge hclk);
        rx_evt <= '0;
        #1;
        n = 0;
        while (backpressure === 1'b1 && n < 2000) begin
            n++;
            @(posedge hclk);
            #1;
        end
        chk("jam cycles", 32'(exp), 32'(n));
        if (n >= 2000) end_sim;
        @(posedge hclk);
    endtask

    initial begin
        tick(3);
        hresetn <= 1'b1;
        tick(1);
        chk("reset outs", 32'h0, 32'({pause_req, backpressure, hw_flow_assert, hresp}));
        ahb(1'b0, 8'hac, 32'h0);
        chk("cfg reset", afc_pkg::CFG_RESET, rd);
        ahb(1'b1, 8'hac, 32'hffff_ffff);
        ahb(1'b0, 8'hac, 32'h0);
        chk("cfg rw", 32'h00ff_ffff, rd);
        ahb(1'b1, 8'h40, 32'hffff_ffff);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, rd);
        ahb(1'b1, 8'hac, 32'h0002_0101); // low kept below high
        tick(20);
        chk("no early zero pause", 32'h0, 32'(n_pause));
        rx_fifo_used <= 16'h007f;
        tick(10);
        chk("below high", 32'h0, 32'({pause_req, hw_flow_assert}));
        rx_fifo_used <= 16'h0080;
        wait_np(8'h01);
        chk("pause time", 32'h1234, 32'(last_time));
        chk("hw flow on", 32'h1, 32'(hw_flow_assert));
        ahb(1'b0, 8'hb0, 32'h0);
        chk("status", 32'h0080_0005, rd);
        tick(20);
        chk("single pause", 32'h2, 32'({n_pause, pause_req}));
        ack_dly      <= 4'h6;
        rx_fifo_used <= 16'h0040;
        tick(20);
        chk("at low", 32'h2, 32'({n_pause, pause_req}));
        rx_fifo_used <= 16'h003f;
        wait_np(8'h02);
        chk("zero time", 32'h0, 32'(last_time));
        chk("hw flow off", 32'h0, 32'(hw_flow_assert));
        ahb(1'b1, 8'hac, 32'h0002_01f8);
        rx_fifo_used <= 16'h00c8;
        tick(5);
        jam(5'h0c, 0);
        chk("fd mcast", 32'h2, 32'(n_pause));
        full_duplex <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            speed_100 <= rows[i].spd;
            ahb(1'b1, 8'hac, {16'h0002, 8'h01, rows[i].cfg});
            tick(2);
            jam(rows[i].evt, rows[i].hit ? mult(rows[i].cfg[7:4]) * STEP
                + (rows[i].spd ? 0 : EXTRA) : 0);
        end
        ahb(1'b1, 8'hac, 32'h0002_0101);
        tx_enabled <= 1'b0;
        tick(2);
        jam(5'h10, 0);
        full_duplex <= 1'b1;
        tick(20);
        chk("tx off", 32'h4, 32'({n_pause, pause_req}));
        hresetn <= 1'b0;
        tick(2);
        hresetn <= 1'b1;
        tick(1);
        chk("reset outs again", 32'h0, 32'({pause_req, backpressure, hw_flow_assert, hresp}));
        ahb(1'b0, 8'hac, 32'h0);
        chk("cfg after reset", 32'h0, rd);
        end_sim;
    end
endmodule
